// ---- logic/gpio_pkg.sv ----
package gpio_pkg;

    // Port geometry: eight pins, two interrupt groups of four pins each.
    localparam int NUM_PINS = 8;
    localparam int NUM_GROUPS = 2;
    localparam int GROUP_PINS = 4;
    localparam int SYNC_STAGES = 2;

    // Which pins can raise an external interrupt request.
    localparam logic [7:0] IRQ_CAPABLE = 8'hFF;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_OPT = 8'h08;
    localparam logic [7:0] OFS_SENS = 8'h0C;

    // Values after reset.
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [3:0] RST_SENS = 4'h0;
    localparam logic [7:0] RST_OE_N = 8'hFF;

    // Field width of each group's sensitivity pair in the sensitivity register.
    localparam int SENS_W = 2;

    // AXI4-Lite responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Interrupt sensitivity of one group, judged on the pin level.
    typedef enum logic [1:0] {
        SENS_LOW_LEVEL,
        SENS_RISING,
        SENS_FALLING,
        SENS_BOTH
    } sens_t;

    // Software-visible port configuration.
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] opt;
        logic [3:0] sens;
    } port_regs_t;

    // Alternate function control from on-chip peripherals.
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] oe;
        logic [7:0] pp;
        logic [7:0] out;
    } alt_ctrl_t;

endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second.
module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Pins float after reset with their pull-ups off, so both stages reset to zero only for a clean start.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

`default_nettype wire

// ---- logic/ext_irq_group.sv ----
`timescale 1ns/1ps
`default_nettype none

// One external interrupt vector: NAND of its enabled pins, event detect, request latch.
module ext_irq_group
    import gpio_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins of the group
    input wire logic [gpio_pkg::GROUP_PINS-1:0] pin_lvl,
    input wire logic [gpio_pkg::GROUP_PINS-1:0] irq_en,
    // Control
    input wire gpio_pkg::sens_t sens,
    input wire logic sens_changed,
    input wire logic vec_fetch,
    // Request
    output logic req
);

    logic nand_line;
    logic prev_ff;
    logic req_ff;
    logic event_hit;
    logic nxt_req;

    // Disabled pins count as high, so one enabled pin held low masks the others.
    assign nand_line = ~&(pin_lvl | ~irq_en);

    // The request latch is hidden from software; fetch or a sensitivity change clears it.
    always_comb begin
        case (sens)
            SENS_LOW_LEVEL: event_hit = nand_line;
            SENS_RISING: event_hit = ~nand_line & prev_ff;
            SENS_FALLING: event_hit = nand_line & ~prev_ff;
            SENS_BOTH: event_hit = nand_line ^ prev_ff;
            default: event_hit = 1'b0;
        endcase
        nxt_req = event_hit | (req_ff & ~vec_fetch & ~sens_changed);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ff <= 1'b0;
            req_ff <= 1'b0;
        end else begin
            prev_ff <= nand_line;
            req_ff <= nxt_req;
        end
    end

    assign req = req_ff;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_FETCH_CLEARS: assert property (vec_fetch && !event_hit |=> !req_ff)
        else $error("request survived its vector fetch");
    AST_SENS_CLEARS: assert property (sens_changed && !event_hit |=> !req_ff)
        else $error("request survived a sensitivity change");
    AST_EVENT_SETS: assert property (event_hit |=> req_ff)
        else $error("pin event did not raise the request");

endmodule

`default_nettype wire

// ---- logic/general_purpose_io_port.sv ----
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Eight pins, each independently input or output.
// - Input pin: data read returns pin level.
// - Input pin: data write updates latch only.
// - Output pin driven by latch; read returns latch.
// - Output option selects push-pull or open drain.
// - Input option selects pull-up; never in output.
// - Interrupt pins raise requests per selected sensitivity.
// - Group interrupt pins combine through a NAND.
// - Hidden request latch clears on vector fetch.
// - Changing sensitivity bits discards pending request.
// - Enabled alternate function output overrides normal settings.
// - Peripheral output forces output mode, its drive.
// - Input pin, peripheral output: read returns peripheral output.
// - Output pin, peripheral input: peripheral sees latch.
// - Input option one: pull-up, enables interrupt.
// - All configuration resets to zero: floating inputs.
module general_purpose_io_port
    import gpio_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Pads
    input wire logic [gpio_pkg::NUM_PINS-1:0] pad_in,
    output logic [gpio_pkg::NUM_PINS-1:0] pad_out,
    output logic [gpio_pkg::NUM_PINS-1:0] pad_oe_n,
    output logic [gpio_pkg::NUM_PINS-1:0] pad_pu,
    // Alternate functions
    input wire gpio_pkg::alt_ctrl_t alt,
    output logic [gpio_pkg::NUM_PINS-1:0] alt_in,
    // Interrupt controller
    input wire logic [gpio_pkg::NUM_GROUPS-1:0] vec_fetch,
    output logic [gpio_pkg::NUM_GROUPS-1:0] ext_irq_req
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    port_regs_t regs_ff, nxt_regs;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [7:0] waddr_ff, nxt_waddr, wbyte_ff, nxt_wbyte;
    logic wstrb0_ff, nxt_wstrb0;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [NUM_GROUPS-1:0] sens_chg_ff, nxt_sens_chg;
    logic [NUM_PINS-1:0] pad_out_ff, nxt_pad_out, pad_oe_n_ff, nxt_pad_oe_n;
    logic [NUM_PINS-1:0] pad_pu_ff, nxt_pad_pu, alt_in_ff, nxt_alt_in;
    logic [NUM_PINS-1:0] pin_sync_lvl, alt_drv, out_mode, drv_val, drv_pp;
    logic [NUM_PINS-1:0] rd_port, irq_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input path

    // Raw pad levels are asynchronous to aclk and must never reach a decision directly.
    pin_sync #(
        .WIDTH(NUM_PINS)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pad_in),
        .q(pin_sync_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin configuration and alternate function muxing

    // A peripheral that drives a pin wins over direction, option and latch.
    always_comb begin
        alt_drv = alt.en & alt.oe;
        out_mode = regs_ff.dir | alt_drv;
        drv_val = (alt_drv & alt.out) | (~alt_drv & regs_ff.latch);
        drv_pp = (alt_drv & alt.pp) | (~alt_drv & regs_ff.opt);
        nxt_pad_out = drv_val;
        nxt_pad_oe_n = ~(out_mode & (drv_pp | ~drv_val));
        nxt_pad_pu = ~out_mode & regs_ff.opt;
        nxt_alt_in = (regs_ff.dir & ~alt_drv & regs_ff.latch)
                   | (~(regs_ff.dir & ~alt_drv) & pin_sync_lvl);
        rd_port = (regs_ff.dir & regs_ff.latch)
                | (~regs_ff.dir & alt_drv & alt.out)
                | (~regs_ff.dir & ~alt_drv & pin_sync_lvl);
        irq_en = ~out_mode & regs_ff.opt & IRQ_CAPABLE;
    end

    // Pad controls are registered so every top output comes from a flip-flop.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_out_ff <= RST_PORT;
            pad_oe_n_ff <= RST_OE_N;
            pad_pu_ff <= RST_PORT;
            alt_in_ff <= RST_PORT;
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_n_ff <= nxt_pad_oe_n;
            pad_pu_ff <= nxt_pad_pu;
            alt_in_ff <= nxt_alt_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External interrupt groups

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_irq
        ext_irq_group u_grp (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_lvl(pin_sync_lvl[g*GROUP_PINS +: GROUP_PINS]),
            .irq_en(irq_en[g*GROUP_PINS +: GROUP_PINS]),
            .sens(sens_t'(regs_ff.sens[g*SENS_W +: SENS_W])),
            .sens_changed(sens_chg_ff[g]),
            .vec_fetch(vec_fetch[g]),
            .req(ext_irq_req[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave and registers

    // Address and data are taken in either order; the write lands once both are held.
    always_comb begin
        nxt_regs = regs_ff;
        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_waddr = waddr_ff;
        nxt_wbyte = wbyte_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_sens_chg = '0;
        if (awvalid && awready_ff) begin
            nxt_aw_got = 1'b1;
            nxt_awready = 1'b0;
            nxt_waddr = awaddr;
        end
        if (wvalid && wready_ff) begin
            nxt_w_got = 1'b1;
            nxt_wready = 1'b0;
            nxt_wbyte = wdata[7:0];
            nxt_wstrb0 = wstrb[0];
        end
        if (aw_got_ff && w_got_ff && !bvalid_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (waddr_ff)
                OFS_DATA: begin
                    // The latch is written even on input pins, so it is ready on turnaround.
                    if (wstrb0_ff) nxt_regs.latch = wbyte_ff;
                end
                OFS_DIR: begin
                    if (wstrb0_ff) nxt_regs.dir = wbyte_ff;
                end
                OFS_OPT: begin
                    if (wstrb0_ff) nxt_regs.opt = wbyte_ff;
                end
                OFS_SENS: begin
                    if (wstrb0_ff) begin
                        nxt_regs.sens = wbyte_ff[3:0];
                        for (int g = 0; g < NUM_GROUPS; g++) begin
                            nxt_sens_chg[g] = wbyte_ff[g*SENS_W +: SENS_W]
                                           != regs_ff.sens[g*SENS_W +: SENS_W];
                        end
                    end
                end
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready = 1'b1;
        end
        // Reads have no side effects, so a read of the data word never disturbs the latch.
        if (arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            case (araddr)
                OFS_DATA: nxt_rdata = {24'h00_0000, rd_port};
                OFS_DIR: nxt_rdata = {24'h00_0000, regs_ff.dir};
                OFS_OPT: nxt_rdata = {24'h00_0000, regs_ff.opt};
                OFS_SENS: nxt_rdata = {28'h000_0000, regs_ff.sens};
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    // Configuration resets to zero, leaving every pin a floating input.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_ff <= '{latch: RST_PORT, dir: RST_PORT, opt: RST_PORT, sens: RST_SENS};
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= 8'h00;
            wbyte_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            sens_chg_ff <= '0;
        end else begin
            regs_ff <= nxt_regs;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            waddr_ff <= nxt_waddr;
            wbyte_ff <= nxt_wbyte;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            sens_chg_ff <= nxt_sens_chg;
        end
    end

    // Output ports are plain copies of registers.
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign pad_out = pad_out_ff;
    assign pad_oe_n = pad_oe_n_ff;
    assign pad_pu = pad_pu_ff;
    assign alt_in = alt_in_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [NUM_PINS-1:0] od_high, pp_drive, in_only;
    assign od_high = regs_ff.dir & ~regs_ff.opt & regs_ff.latch & ~alt.en;
    assign pp_drive = regs_ff.dir & regs_ff.opt & ~alt.en;
    assign in_only = ~regs_ff.dir & ~(alt.en & alt.oe);

    sequence data_read_taken;
        arvalid && arready_ff && araddr == OFS_DATA;
    endsequence

    sequence input_data_write;
        aw_got_ff && w_got_ff && !bvalid_ff && waddr_ff == OFS_DATA && in_only == 8'hFF;
    endsequence

    AST_OD_FLOATS: assert property (od_high != 8'h00 |=>
        (pad_oe_n_ff & $past(od_high)) == $past(od_high))
        else $error("open drain high was driven");
    AST_PP_DRIVES: assert property (pp_drive != 8'h00 |=>
        (pad_oe_n_ff & $past(pp_drive)) == 8'h00 &&
        (pad_out_ff & $past(pp_drive)) == ($past(regs_ff.latch) & $past(pp_drive)))
        else $error("push-pull pin not driven from latch");
    AST_NO_PULLUP_OUT: assert property (1'b1 |=> (pad_pu_ff & $past(regs_ff.dir)) == 8'h00)
        else $error("pull-up on while pin is an output");
    AST_INPUT_WRITE: assert property (input_data_write ##1 in_only == 8'hFF |=>
        pad_oe_n_ff == 8'hFF)
        else $error("data write disturbed an input pin");
    AST_READ_DATA: assert property (data_read_taken |=>
        rvalid_ff && rdata_ff[7:0] == $past(rd_port) && rdata_ff[31:8] == 24'h00_0000)
        else $error("data read did not return pin or latch");
    AST_ALT_FORCE_OUT: assert property ((alt.en & alt.oe & alt.pp) != 8'h00 |=>
        (pad_oe_n_ff & $past(alt.en & alt.oe & alt.pp)) == 8'h00)
        else $error("peripheral output did not force drive");
    AST_ALT_IN_LATCH: assert property (1'b1 |=>
        (alt_in_ff & $past(regs_ff.dir & ~alt.oe)) ==
        ($past(regs_ff.latch) & $past(regs_ff.dir & ~alt.oe)))
        else $error("peripheral input did not see the latch");
    AST_WRITE_RESP: assert property (aw_got_ff && w_got_ff && !bvalid_ff |=> bvalid_ff [*1])
        else $error("write response missing");

endmodule

`default_nettype wire

// ---- sim/pad_world.sv ----
`timescale 1ns/1ps
`default_nettype none

// Board around the port: external drivers, pull-ups and undriven pads.
module pad_world
    import gpio_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Port side
    input wire logic [gpio_pkg::NUM_PINS-1:0] pad_out,
    input wire logic [gpio_pkg::NUM_PINS-1:0] pad_oe_n,
    input wire logic [gpio_pkg::NUM_PINS-1:0] pad_pu,
    // Board side
    input wire logic [gpio_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [gpio_pkg::NUM_PINS-1:0] ext_val,
    output logic [gpio_pkg::NUM_PINS-1:0] pad_in
);
    logic [7:0] float_ff;

    // An undriven pad wanders every cycle, so a stale level never passes for a real one.
    always_ff @(posedge aclk) begin
        float_ff <= aresetn ? ~float_ff : 8'h5A;
    end

    // Pad level: port drive first, then board drive, then pull-up, else wandering.
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pu[i]) pad_in[i] = 1'b1;
            else pad_in[i] = float_ff[i];
        end
    end
endmodule

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import gpio_pkg::*;

    typedef struct packed {
        logic [7:0] dir, opt, latch, een, eval, rd, oe_n, pu;
    } row_t;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, pad_in, pad_out, pad_oe_n, pad_pu, alt_in, ext_en, ext_val;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, vec_fetch, ext_irq_req;
    alt_ctrl_t alt;
    int fails, comparisons;
    // Columns: dir, opt, latch, board enable, board value, data read, oe_n, pull-up.
    row_t rows [5] = '{
        '{8'h00, 8'h00, 8'hA5, 8'hFF, 8'h3C, 8'h3C, 8'hFF, 8'h00},
        '{8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'hF0, 8'hFF, 8'hFF},
        '{8'hFF, 8'hFF, 8'h5A, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h00},
        '{8'hFF, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h5A, 8'h5A, 8'h00},
        '{8'hF0, 8'h0F, 8'hC3, 8'h0F, 8'h09, 8'hC9, 8'hCF, 8'h0F}};

    general_purpose_io_port dut_u (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_pu(pad_pu), .alt(alt), .alt_in(alt_in),
        .vec_fetch(vec_fetch), .ext_irq_req(ext_irq_req));

    pad_world world_u (
        .aclk(aclk), .aresetn(aresetn), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pu(pad_pu), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    // 20 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons and verdict.
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master: each channel is held until its own handshake edge.
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        bit aw_ok = 1'b0;
        bit w_ok = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        chk_resp("bresp", er, bresp);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input string what, input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        bit ar_ok = 1'b0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready && !ar_ok) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
        end while (!(ar_ok && rvalid));
        chk_reg(what, ed, rdata);
        chk_resp(what, er, rresp);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi_wr(a, d, 4'hF, RESP_OKAY);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] e);
        axi_rd(what, a, {24'h00_0000, e}, RESP_OKAY);
    endtask

    // Board drives new pad levels; interrupt controller fetches vectors.
    task automatic drive(input logic [7:0] v);
        @(posedge aclk);
        ext_val <= v;
    endtask

    task automatic fetch(input logic [1:0] v);
        @(posedge aclk);
        vec_fetch <= v;
        @(posedge aclk);
        vec_fetch <= 2'b00;
    endtask

    task automatic irq_chk(input int n, input logic [1:0] e);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
        chk_pin("ext_irq_req", {6'h00, e}, {6'h00, ext_irq_req});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The run is short; a hang trips this long after it.
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, vec_fetch} = '0;
        alt = '0;
        ext_en = 8'hFF;
        ext_val = 8'h00;
        fails = 0;
        comparisons = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk_pin("pad_oe_n", 8'hFF, pad_oe_n);
        chk_pin("pad_pu", 8'h00, pad_pu);
        rd("dir", OFS_DIR, 8'h00);
        rd("opt", OFS_OPT, 8'h00);
        rd("data", OFS_DATA, 8'h00);
        axi_wr(8'h10, 8'hFF, 4'hF, RESP_SLVERR);
        axi_rd("unmapped", 8'h10, 32'h0000_0000, RESP_SLVERR);
        axi_wr(OFS_DIR, 8'hFF, 4'h0, RESP_OKAY);
        rd("dir no strobe", OFS_DIR, 8'h00);
        $display("test reset and bus done");
        // Only whole-byte writes; no read-modify-write of the data location.
        foreach (rows[i]) begin
            @(posedge aclk);
            ext_en <= ext_en & rows[i].een;
            wr(OFS_DATA, rows[i].latch);
            wr(OFS_OPT, rows[i].opt);
            wr(OFS_DIR, rows[i].dir);
            @(posedge aclk);
            ext_en <= rows[i].een;
            ext_val <= rows[i].eval;
            rd("dir", OFS_DIR, rows[i].dir);
            rd("opt", OFS_OPT, rows[i].opt);
            rd("data", OFS_DATA, rows[i].rd);
            @(negedge aclk);
            chk_pin("pad_oe_n", rows[i].oe_n, pad_oe_n);
            chk_pin("pad_out", rows[i].latch & ~rows[i].oe_n, pad_out & ~pad_oe_n);
            chk_pin("pad_pu", rows[i].pu, pad_pu);
        end
        $display("test pin modes done");
        @(posedge aclk);
        ext_en <= 8'h00;
        wr(OFS_DATA, 8'h02);
        wr(OFS_OPT, 8'h00);
        wr(OFS_DIR, 8'h02);
        @(posedge aclk);
        ext_en <= 8'hFC;
        ext_val <= 8'h04;
        alt <= {8'h07, 8'h01, 8'h01, 8'h01};
        rd("dir", OFS_DIR, 8'h02);
        rd("data alt", OFS_DATA, 8'h07);
        @(negedge aclk);
        chk_pin("alt drive", 8'h00, pad_oe_n & 8'h01);
        chk_pin("alt level", 8'h01, pad_out & 8'h01);
        chk_pin("alt_in", 8'h06, alt_in & 8'h06);
        @(posedge aclk);
        alt.pp <= 8'h00;
        repeat (2) @(negedge aclk);
        chk_pin("alt release", 8'h01, pad_oe_n & 8'h01);
        @(posedge aclk);
        alt.out <= 8'h00;
        repeat (2) @(negedge aclk);
        chk_pin("alt sink", 8'h00, (pad_oe_n | pad_out) & 8'h01);
        @(posedge aclk);
        alt <= '0;
        $display("test alternate function done");
        wr(OFS_DIR, 8'h00);
        @(posedge aclk);
        ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        wr(OFS_SENS, 8'h06);
        rd("sens", OFS_SENS, 8'h06);
        wr(OFS_OPT, 8'h0C);
        fetch(2'b11);
        irq_chk(3, 2'b00);
        drive(8'hF7);
        irq_chk(2, 2'b00);
        irq_chk(1, 2'b01);
        wr(OFS_SENS, 8'h05);
        irq_chk(3, 2'b00);
        drive(8'hFF);
        irq_chk(4, 2'b01);
        fetch(2'b01);
        irq_chk(1, 2'b00);
        drive(8'hFB);
        irq_chk(4, 2'b00);
        drive(8'hF3);
        drive(8'hFB);
        irq_chk(4, 2'b00);
        wr(OFS_SENS, 8'h04);
        irq_chk(4, 2'b01);
        drive(8'hFF);
        // The low level takes two edges to clear the synchroniser; a fetch before then is re-set.
        repeat (2) @(posedge aclk);
        fetch(2'b01);
        irq_chk(2, 2'b00);
        wr(OFS_SENS, 8'h07);
        irq_chk(3, 2'b00);
        drive(8'hF7);
        irq_chk(4, 2'b01);
        $display("test interrupts done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk_pin("pad_oe_n", 8'hFF, pad_oe_n);
        chk_pin("pad_pu", 8'h00, pad_pu);
        irq_chk(0, 2'b00);
        rd("opt", OFS_OPT, 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
